/* File: rtl/ctbs_defines.vh */
`ifndef CTBS_DEFINES_VH
`define CTBS_DEFINES_VH

// Buffer count and per-buffer layout
`define CTBS_NBUF 3
`define CTBS_MSG_BYTES 13
`define CTBS_LOCAL_PRIORITY_IDX 4'hd
`define CTBS_TSH_IDX 4'he
`define CTBS_TSL_IDX 4'hf
`define CTBS_SLOT_BYTES 16

// Register byte offsets
`define CTBS_OFF_FLAG 12'h000
`define CTBS_OFF_SEL 12'h004
`define CTBS_OFF_ISTAT 12'h008
`define CTBS_OFF_IMASK 12'h00c
`define CTBS_OFF_STAT 12'h010
`define CTBS_WIN_TAG 6'h01

// Interrupt event layout
`define CTBS_IEV_W 6
`define CTBS_IEV_DONE_LSB 0
`define CTBS_IEV_LOST_LSB 3

// Reset values
`define CTBS_FLAG_RST 3'h7
`define CTBS_SEL_RST 3'h0
`define CTBS_IMASK_RST 6'h00
`define CTBS_ISTAT_RST 6'h00

// Sequencer states
`define CTBS_ST_IDLE 2'h0
`define CTBS_ST_OFFER 2'h1
`define CTBS_ST_SEND 2'h2

`endif

/* File: rtl/ctbs_irq.v */
`timescale 1ns/1ps
// Sticky event flags, write-one-to-clear, masked onto one level
module ctbs_irq #(
   parameter W = 6
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] ev_set,
   input wire clr_wr,
   input wire mask_wr,
   input wire [W-1:0] wdata,
   output reg [W-1:0] status,
   output reg [W-1:0] mask,
   output wire irq
);
   // Level interrupt while any unmasked flag stands
   assign irq = |(status & mask);

   // A new event wins over a clear in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= {W{1'b0}};
         mask <= {W{1'b0}};
      end else begin
         status <= (status & ~(clr_wr ? wdata : {W{1'b0}})) | ev_set;
         if (mask_wr) begin
            mask <= wdata;
         end
      end
   end
endmodule

/* File: rtl/ctbs_local_priority_pick.v */
`timescale 1ns/1ps
// Chooses the ready buffer with the smallest priority value
module ctbs_local_priority_pick #(
   parameter N = 3
) (
   input wire [N-1:0] ready,
   input wire [8*N-1:0] local_priority_flat,
   output reg any,
   output reg [1:0] idx
);
   integer i;
   reg [7:0] best;

   // Strict compare keeps the lower index on equal values
   always @* begin
      any = 1'b0;
      idx = 2'h0;
      best = 8'hff;
      for (i = 0; i < N; i = i + 1) begin
         if (ready[i] && (!any || local_priority_flat[8*i +: 8] < best)) begin
            any = 1'b1;
            idx = i[1:0];
            best = local_priority_flat[8*i +: 8];
         end
      end
   end
endmodule

/* File: rtl/ctbs_top.v */
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ctbs_defines.vh"
module ctbs_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire irq,
   output wire tx_valid,
   output reg [1:0] tx_buf,
   input wire tx_take,
   input wire tx_done,
   input wire tx_lost,
   input wire [3:0] tx_rd_idx,
   output reg [7:0] tx_rd_byte,
   output wire bus_hold,
   input wire [15:0] time_now
);
   // Buffer storage, one slot of sixteen bytes per buffer
   // Three slots, fixed; the picker and one-hot select assume it
   localparam MEM_D = `CTBS_NBUF * `CTBS_SLOT_BYTES;

   // Flat storage index of a buffer byte
   function [5:0] mem_ix;
      input [1:0] b;
      input [3:0] n;
      begin
         mem_ix = {b, n};
      end
   endfunction

   // Index of a one-hot buffer bit
   function [1:0] hot_ix;
      input [2:0] h;
      begin
         if (h[1]) begin
            hot_ix = 2'h1;
         end else if (h[2]) begin
            hot_ix = 2'h2;
         end else begin
            hot_ix = 2'h0;
         end
      end
   endfunction

   // Lowest set bit kept, others dropped
   function [2:0] lowest;
      input [2:0] v;
      begin
         if (v[0]) begin
            lowest = 3'h1;
         end else if (v[1]) begin
            lowest = 3'h2;
         end else if (v[2]) begin
            lowest = 3'h4;
         end else begin
            lowest = 3'h0;
         end
      end
   endfunction

   // Buffer bytes
   // Bytes 0..12 message, 13 priority, 14..15 stamp
   // Stamp bytes are written only by hardware
   reg [7:0] buf_mem [0:MEM_D-1];
   // Per-buffer empty flags
   // Set means free for software, clear means ready to send
   // Completion sets a flag even in a clearing write
   reg [2:0] empty;
   // One-hot window selection
   // Zero means no buffer mapped into the window
   // Not cleared when its buffer is released for sending
   reg [2:0] sel;
   // Sequencer state
   reg [1:0] state;
   // Offered candidate
   reg [1:0] cand;
   // Buffer being sent
   reg [1:0] act;
   // Picker results
   wire pick_any;
   wire [1:0] pick_idx;
   // Ready mask seen by the picker
   wire [2:0] pick_mask;
   // Interrupt register views
   wire [`CTBS_IEV_W-1:0] istat;
   wire [`CTBS_IEV_W-1:0] imask;
   // Events raised this cycle
   reg [2:0] ev_done;
   reg [2:0] ev_lost;
   // Bus decode
   wire acc;
   wire wr;
   wire setup_rd;
   wire is_win;
   wire hit;
   wire [1:0] win_buf;
   wire [3:0] win_byte;
   wire win_ok;
   // Next read word
   reg [31:0] next_rd;
   integer k;

   // Zero wait states; errors only on unmapped offsets
   // Every access phase ends in its first cycle
   // Read data is settled one cycle before it is taken
   // Writes land at the edge that closes the access
   // Window writes to a busy buffer are dropped quietly
   // A bad offset answers an error and changes nothing
   // Reads of unused bits return zero
   assign pready = 1'b1;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign is_win = (paddr[11:6] == `CTBS_WIN_TAG);
   assign hit = is_win ||
      paddr == `CTBS_OFF_FLAG || paddr == `CTBS_OFF_SEL ||
      paddr == `CTBS_OFF_ISTAT || paddr == `CTBS_OFF_IMASK ||
      paddr == `CTBS_OFF_STAT;
   assign pslverr = acc & ~hit;

   // Window shows the selected buffer only
   assign win_buf = hot_ix(sel);
   assign win_byte = paddr[5:2];
   assign win_ok = (sel != 3'h0);

   // Sending buffer is excluded so the next one is ready at completion
   assign pick_mask = ~empty &
      ((state == `CTBS_ST_SEND) ? ~(3'h1 << act) : 3'h7);

   // Priority comparison among ready buffers
   ctbs_local_priority_pick #(
      .N(`CTBS_NBUF)
   ) u_pick (
      .ready(pick_mask),
      .local_priority_flat({buf_mem[mem_ix(2'h2, `CTBS_LOCAL_PRIORITY_IDX)],
                  buf_mem[mem_ix(2'h1, `CTBS_LOCAL_PRIORITY_IDX)],
                  buf_mem[mem_ix(2'h0, `CTBS_LOCAL_PRIORITY_IDX)]}),
      .any(pick_any),
      .idx(pick_idx)
   );

   // Event flags and interrupt line
   ctbs_irq #(
      .W(`CTBS_IEV_W)
   ) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .ev_set({ev_lost, ev_done}),
      .clr_wr(wr && paddr == `CTBS_OFF_ISTAT),
      .mask_wr(wr && paddr == `CTBS_OFF_IMASK),
      .wdata(pwdata[`CTBS_IEV_W-1:0]),
      .status(istat),
      .mask(imask),
      .irq(irq)
   );

   // Handshake outputs to the protocol engine
   assign tx_valid = (state == `CTBS_ST_OFFER);
   assign bus_hold = (empty != 3'h7);

   // Completion and loss events of the active buffer
   always @* begin
      ev_done = 3'h0;
      ev_lost = 3'h0;
      if (state == `CTBS_ST_SEND) begin
         if (tx_done) begin
            ev_done = 3'h1 << act;
         end else if (tx_lost) begin
            ev_lost = 3'h1 << act;
         end
      end
   end

   // Empty flags: software clear requests sending, completion sets
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         empty <= `CTBS_FLAG_RST;
      end else begin
         if (wr && paddr == `CTBS_OFF_FLAG) begin
            empty <= (empty & ~pwdata[2:0]) | ev_done;
         end else begin
            empty <= empty | ev_done;
         end
      end
   end

   // Selection keeps only the lowest requested free buffer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel <= `CTBS_SEL_RST;
      end else if (wr && paddr == `CTBS_OFF_SEL) begin
         sel <= lowest(pwdata[2:0] & empty);
      end
   end

   // Buffer byte storage: software loads, hardware stamps
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (k = 0; k < MEM_D; k = k + 1) begin
            buf_mem[k] <= 8'h00;
         end
      end else begin
         // Loading allowed only while the selected buffer is free
         if (wr && is_win && win_ok && empty[win_buf] &&
             win_byte <= `CTBS_LOCAL_PRIORITY_IDX) begin
            buf_mem[mem_ix(win_buf, win_byte)] <= pwdata[7:0];
         end
         // Time stamp taken when the message completes
         if (ev_done != 3'h0) begin
            buf_mem[mem_ix(act, `CTBS_TSH_IDX)] <= time_now[15:8];
            buf_mem[mem_ix(act, `CTBS_TSL_IDX)] <= time_now[7:0];
         end
      end
   end

   // Transmit sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= `CTBS_ST_IDLE;
         cand <= 2'h0;
         act <= 2'h0;
      end else begin
         case (state)
            `CTBS_ST_IDLE: begin
               // Start offering once anything is ready
               if (pick_any) begin
                  cand <= pick_idx;
                  state <= `CTBS_ST_OFFER;
               end
            end
            `CTBS_ST_OFFER: begin
               // Engine accepts the current candidate, which the registered tx_buf shows only from the next cycle
               if (tx_take) begin
                  act <= cand;
                  state <= `CTBS_ST_SEND;
               end else begin
                  // A better buffer may overtake before acceptance
                  cand <= pick_idx;
               end
            end
            `CTBS_ST_SEND: begin
               if (tx_done) begin
                  // Go straight to the next ready buffer
                  if (pick_any) begin
                     cand <= pick_idx;
                     state <= `CTBS_ST_OFFER;
                  end else begin
                     state <= `CTBS_ST_IDLE;
                  end
               end else if (tx_lost) begin
                  // Buffer stays ready and competes again
                  state <= `CTBS_ST_IDLE;
               end
            end
            default: begin
               state <= `CTBS_ST_IDLE;
            end
         endcase
      end
   end

   // Candidate index and message bytes to the engine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buf <= 2'h0;
         tx_rd_byte <= 8'h00;
      end else begin
         tx_buf <= (state == `CTBS_ST_SEND) ? act : cand;
         if (state == `CTBS_ST_SEND) begin
            tx_rd_byte <= buf_mem[mem_ix(act, tx_rd_idx)];
         end else begin
            tx_rd_byte <= buf_mem[mem_ix(cand, tx_rd_idx)];
         end
      end
   end

   // Read mux; unused bits read zero
   always @* begin
      next_rd = 32'h0000_0000;
      if (is_win) begin
         if (win_ok) begin
            next_rd[7:0] = buf_mem[mem_ix(win_buf, win_byte)];
         end
      end else begin
         case (paddr)
            `CTBS_OFF_FLAG: begin
               next_rd[2:0] = empty;
            end
            `CTBS_OFF_SEL: begin
               next_rd[2:0] = sel;
            end
            `CTBS_OFF_ISTAT: begin
               next_rd[`CTBS_IEV_W-1:0] = istat;
            end
            `CTBS_OFF_IMASK: begin
               next_rd[`CTBS_IEV_W-1:0] = imask;
            end
            `CTBS_OFF_STAT: begin
               next_rd[5:0] = {cand, act, state};
            end
            default: begin
               next_rd = 32'h0000_0000;
            end
         endcase
      end
   end

   // Read data captured in the setup cycle, stable through access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata <= next_rd;
      end
   end
endmodule

/* File: test/ctbs_engine_model.sv */
`timescale 1ns/1ps
// Bus-side engine: takes offers, reads a byte, ends frames
module ctbs_engine_model (
   input wire pclk,
   input wire presetn,
   input wire tx_valid,
   input wire [1:0] tx_buf,
   input wire [7:0] tx_rd_byte,
   output reg tx_take = 1'b0,
   output reg tx_done = 1'b0,
   output reg tx_lost = 1'b0,
   output reg [3:0] tx_rd_idx = 4'h0,
   output reg [15:0] time_now = 16'h0000
);
   reg [1:0] log_b [0:15]; // Buffer of each attempt
   reg [7:0] log_d [0:15]; // Byte read in frame
   reg [15:0] log_t [0:15]; // Timer at completion
   reg log_l [0:15]; // Attempt lost
   integer n = 0;
   integer gap = 2; // Frame length, raised to stall
   reg lose_once = 1'b0; // Lose next arbitration
   reg [1:0] b;
   // Free running timer
   always @(posedge pclk) begin
      time_now <= time_now + 16'h0103;
   end
   // Frame loop, back to back when offered
   // Samples on the falling edge, drives just after the rising one
   initial begin
      forever begin
         @(negedge pclk);
         if (presetn && tx_valid) begin
            @(posedge pclk);
            tx_take <= 1'b1;
            tx_rd_idx <= n[3:0];
            @(negedge pclk);
            b = tx_buf;
            @(posedge pclk);
            tx_take <= 1'b0;
            repeat (gap) @(posedge pclk);
            @(negedge pclk);
            log_d[n] = tx_rd_byte;
            @(posedge pclk);
            tx_lost <= lose_once;
            tx_done <= !lose_once;
            @(negedge pclk);
            log_b[n] = b;
            log_l[n] = lose_once;
            log_t[n] = time_now;
            @(posedge pclk);
            n = n + 1;
            lose_once = 1'b0;
            tx_done <= 1'b0;
            tx_lost <= 1'b0;
         end
      end
   end
endmodule

/* File: test/ctbs_props.sv */
`timescale 1ns/1ps
// Port checker for offer, send and bus answers
module ctbs_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire tx_valid,
   input wire [1:0] tx_buf,
   input wire tx_take,
   input wire tx_done,
   input wire tx_lost,
   input wire bus_hold
);
   reg sending; // Frame granted, not yet closed
   // Follows take until done or lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sending <= 1'b0;
      end else if (tx_valid && tx_take) begin
         sending <= 1'b1;
      end else if (tx_done || tx_lost) begin
         sending <= 1'b0;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && penable |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_err; psel && penable && paddr > 12'h07f |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no slverr");
   property p_three; tx_valid |-> tx_buf != 2'h3; endproperty
   a_three: assert property (p_three) else $error("bad index");
   property p_hold; tx_valid |-> bus_hold; endproperty
   a_hold: assert property (p_hold) else $error("offer no hold");
   property p_stay; tx_valid && !tx_take |=> tx_valid; endproperty
   a_stay: assert property (p_stay) else $error("offer dropped");
   property p_send; sending |-> !tx_valid; endproperty
   a_send: assert property (p_send) else $error("offer in send");
   property p_next; sending && tx_done ##1 bus_hold |-> tx_valid; endproperty
   a_next: assert property (p_next) else $error("late next");
   property p_lost;
      sending && tx_lost && !tx_done |=> !tx_valid ##[1:2] tx_valid;
   endproperty
   a_lost: assert property (p_lost) else $error("no retry");
endmodule
bind ctbs_top ctbs_props u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .tx_valid(tx_valid), .tx_buf(tx_buf),
   .tx_take(tx_take), .tx_done(tx_done), .tx_lost(tx_lost),
   .bus_hold(bus_hold));

/* File: test/ctbs_top_tb_top.sv */
`timescale 1ns/1ps
module ctbs_top_tb_top;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, irq, tx_valid, tx_take, tx_done, tx_lost, bus_hold;
   wire [1:0] tx_buf;
   wire [3:0] tx_rd_idx;
   wire [7:0] tx_rd_byte;
   wire [15:0] time_now;
   integer bad_count = 0;
   integer comparisons = 0;
   integer i;
   reg [31:0] q; // Last read data
   reg qe; // Last error answer
   always #2 pclk = ~pclk;
   ctbs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .tx_valid(tx_valid), .tx_buf(tx_buf), .tx_take(tx_take),
      .tx_done(tx_done), .tx_lost(tx_lost), .tx_rd_idx(tx_rd_idx),
      .tx_rd_byte(tx_rd_byte), .bus_hold(bus_hold), .time_now(time_now));
   ctbs_engine_model eng (.pclk(pclk), .presetn(presetn),
      .tx_valid(tx_valid), .tx_buf(tx_buf), .tx_rd_byte(tx_rd_byte),
      .tx_take(tx_take), .tx_done(tx_done), .tx_lost(tx_lost),
      .tx_rd_idx(tx_rd_idx), .time_now(time_now));
   // Counts and reports one comparison
   task chk(input [31:0] g, input [31:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   // One APB transfer, then an idle cycle
   task apb(input [11:0] a, input w, input [31:0] d);
      begin
         psel <= 1'b1;
         paddr <= a;
         pwrite <= w;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         q = prdata;
         qe = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rc(input [11:0] a, input [31:0] e);
      begin
         apb(a, 1'b0, 32'h0);
         chk(q, e);
      end
   endtask
   // Polls flags until all buffers are free
   task wempty;
      integer k;
      begin
         q = 32'h0;
         for (k = 0; k < 200 && q !== 32'h7; k = k + 1) apb(12'h000, 1'b0, 0);
         chk(q, 32'h7);
      end
   endtask
   // Selects a buffer and fills message and priority
   task load(input [1:0] b, input [7:0] p);
      integer k;
      begin
         apb(12'h004, 1'b1, {29'h0, 3'h1 << b});
         rc(12'h004, {29'h0, 3'h1 << b});
         for (k = 0; k < 13; k = k + 1)
            apb({k[9:0], 2'b00} + 12'h040, 1'b1, {26'h0, b, k[3:0]});
         apb(12'h074, 1'b1, {24'h0, p});
         rc(12'h070, {26'h0, b, 4'hc});
         rc(12'h074, {24'h0, p});
      end
   endtask
   task s_reset;
      begin
         rc(12'h000, 32'h7);
         rc(12'h004, 32'h0);
         chk({31'h0, bus_hold}, 32'h0);
         rc(12'h020, 32'h0);
         chk({31'h0, qe}, 32'h1);
      end
   endtask
   task s_sel;
      begin
         apb(12'h004, 1'b1, 32'h6);
         rc(12'h004, 32'h2);
         apb(12'h004, 1'b1, 32'h5);
         rc(12'h004, 32'h1);
         apb(12'h078, 1'b1, 32'haa);
         rc(12'h078, 32'h0);
      end
   endtask
   task s_local_priority;
      begin
         load(0, 8'h05);
         load(1, 8'h02);
         load(2, 8'h02);
         apb(12'h000, 1'b1, 32'h7);
         wempty;
         chk({30'h0, eng.log_b[0]}, 32'h1);
         chk({30'h0, eng.log_b[1]}, 32'h2);
         chk({30'h0, eng.log_b[2]}, 32'h0);
         chk({24'h0, eng.log_d[2]}, 32'h02);
         rc(12'h008, 32'h7);
         chk({31'h0, irq}, 32'h0);
         apb(12'h00c, 1'b1, 32'h1);
         chk({31'h0, irq}, 32'h1);
         apb(12'h008, 1'b1, 32'h1);
         chk({31'h0, irq}, 32'h0);
         rc(12'h008, 32'h6);
         apb(12'h008, 1'b1, 32'h6);
         apb(12'h004, 1'b1, 32'h2);
         rc(12'h078, {24'h0, eng.log_t[0][15:8]});
         rc(12'h07c, {24'h0, eng.log_t[0][7:0]});
      end
   endtask
   task s_lost;
      begin
         load(0, 8'h00);
         eng.lose_once = 1'b1;
         apb(12'h000, 1'b1, 32'h1);
         wempty;
         chk({31'h0, eng.log_l[3], eng.log_l[4]}, 32'h2);
         chk({30'h0, eng.log_b[4]}, 32'h0);
         rc(12'h008, 32'h9);
      end
   endtask
   task s_busy;
      begin
         load(2, 8'h01);
         eng.gap = 40;
         apb(12'h000, 1'b1, 32'h4);
         apb(12'h040, 1'b1, 32'hee);
         rc(12'h000, 32'h3);
         chk({31'h0, bus_hold}, 32'h1);
         wempty;
         eng.gap = 2;
         rc(12'h040, 32'h20);
      end
   endtask
   task wrap_up;
      begin
         $display("Counts: %0d errors, %0d comparisons", bad_count,
            comparisons);
         if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_reset;
      s_sel;
      s_local_priority;
      s_lost;
      s_busy;
      wrap_up;
   end
   // Watchdog
   initial begin
      #40000;
      bad_count = bad_count + 1;
      wrap_up;
   end
endmodule
